// ### remappable_input_pin_select.sv
// Remappable pin select: input selectors, two output functions, lock
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Mapping writes ignored while lock bit set
// - Selector register set provided by this unit
// - Unimplemented selector bits read zero
// - Selector fields reset to all ones
// - Register 0 bits 13-8 select irq1
// - Register 1 holds irq3 high, irq2 low
// - Register 2 bits 5-0 select irq4
// - Register 3 holds timer3, timer2 clocks
// - Register 4 holds timer5, timer4 clocks
// - Register 7 holds capture2, capture1
// - Register 8 holds capture4, capture3
// - Register 9 holds capture6, capture5
// - Field value is the driving pin index
// - Output code 3 drives serial transmit
// - Output code 4 drives serial request-to-send
// - Selector beyond implemented pins gives no input
// - Reset: inputs grounded, outputs disconnected
// - Lock bit resets cleared
module remappable_input_pin_select #(
   parameter int NUM_PINS = 46
) (
   input wire logic i_clk, // System clock, 25 MHz
   input wire logic i_rst_n, // Synchronous reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction, high = write
   input wire logic [11:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   input wire logic [3:0] i_pstrb, // APB byte strobes
   output logic o_pready, // APB ready
   output logic [31:0] o_prdata, // APB read data
   output logic o_pslverr, // APB error on unmapped address
   input wire logic [NUM_PINS-1:0] i_pin_in, // Remappable pin levels
   input wire logic i_ser1_tx, // Serial port 1 transmit
   input wire logic i_ser1_rts, // Serial port 1 request-to-send
   output logic [NUM_PINS-1:0] o_pin_out, // Pin output levels
   output logic [NUM_PINS-1:0] o_pin_oe_n, // Pin drive enable, low
   output pin_select_pkg::periph_in_s o_periph // Mapped peripheral inputs
);

   localparam int NF = pin_select_pkg::NUM_FIELDS;
   localparam int SW = pin_select_pkg::SEL_W;
   localparam logic [SW:0] PIN_LIMIT = (SW+1)'(NUM_PINS);

   // Reset code 63 must stay invalid, and pins 2 and 3 must exist;
   // refused while elaborating so no run starts with a broken map
   if (NUM_PINS > pin_select_pkg::IDX_SPAN - 1 ||
       NUM_PINS <= pin_select_pkg::OUT_PIN_B) begin : g_bad_pins
      $error("NUM_PINS out of range");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [NF-1:0][SW-1:0] field_q;
   logic [1:0][SW-1:0] out_fn_q;
   logic lock_q;
   pin_select_pkg::unlock_e unl_q;
   pin_select_pkg::unlock_e unl_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [NUM_PINS-1:0] pin_s1_q;
   logic [NUM_PINS-1:0] pin_s2_q;
   pin_select_pkg::periph_in_s periph_q;
   logic [NUM_PINS-1:0] pin_out_q;
   logic [NUM_PINS-1:0] pin_oe_n_q;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic [3:0] reg_idx;
   logic in_hit;
   logic out_hit;
   logic osc_hit;
   logic mapped;
   logic access;
   logic wr_fire;
   logic map_wr_ok;
   logic [7:0] osc_byte;

   // Selector index is the word index; offsets above 0x3C miss
   assign reg_idx = i_paddr[5:2];
   assign in_hit = (i_paddr[11:6] == 6'h00) &&
                   pin_select_pkg::IN_REG_MAP[reg_idx];
   assign out_hit = (i_paddr[11:2] == pin_select_pkg::OUT_SEL_OFFSET[11:2]);
   assign osc_hit = (i_paddr[11:2] == pin_select_pkg::OSC_CTRL_OFFSET[11:2]);
   assign mapped = in_hit || out_hit || osc_hit;
   assign access = i_psel && i_penable;
   assign wr_fire = access && pready_q && i_pwrite;
   assign map_wr_ok = wr_fire && !lock_q;
   assign osc_byte = i_pwdata[7:0];

   // ------------------------------------------------------------
   // Input selector fields
   // ------------------------------------------------------------
   logic [NF-1:0] fld_we;
   logic [NF-1:0][SW-1:0] fld_wd;
   logic [NF-1:0] pick;
   logic [pin_select_pkg::IDX_SPAN-1:0] pin_ext;

   // Padding keeps every six-bit index inside the vector
   assign pin_ext = {(pin_select_pkg::IDX_SPAN-NUM_PINS)'(0), pin_s2_q};

   // table-driven selector set; byte strobes gate each half
   for (genvar f = 0; f < NF; f++) begin : g_field
      localparam bit HI = pin_select_pkg::FIELD_HI[f];
      localparam int LSB = HI ? pin_select_pkg::HI_LSB
                              : pin_select_pkg::LO_LSB;
      localparam int STB = HI ? pin_select_pkg::STRB_HI
                              : pin_select_pkg::STRB_LO;
      assign fld_we[f] = map_wr_ok && in_hit && i_pstrb[STB] &&
                         (reg_idx == pin_select_pkg::FIELD_REG[f]);
      assign fld_wd[f] = i_pwdata[LSB +: SW];
      // pin index mux, invalid index reads low
      assign pick[f] = ({1'b0, field_q[f]} < PIN_LIMIT) ?
                       pin_ext[field_q[f]] : 1'b0;
   end
   // fields reset to all ones, which selects no pin
   always_ff @(posedge i_clk) begin
      for (int f = 0; f < NF; f++) begin
         if (!i_rst_n) begin
            field_q[f] <= pin_select_pkg::IN_SEL_RESET;
         end else if (fld_we[f]) begin
            field_q[f] <= fld_wd[f];
         end
      end
   end

   // ------------------------------------------------------------
   // Output function fields for pins 2 and 3
   // ------------------------------------------------------------
   logic out_we_lo;
   logic out_we_hi;

   assign out_we_lo = map_wr_ok && out_hit &&
                      i_pstrb[pin_select_pkg::STRB_LO];
   assign out_we_hi = map_wr_ok && out_hit &&
                      i_pstrb[pin_select_pkg::STRB_HI];

   // output functions reset to the null code
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         out_fn_q <= {2{pin_select_pkg::OUT_FN_RESET}};
      end else begin
         if (out_we_lo) begin
            out_fn_q[0] <= i_pwdata[pin_select_pkg::LO_LSB +: SW];
         end
         if (out_we_hi) begin
            out_fn_q[1] <= i_pwdata[pin_select_pkg::HI_LSB +: SW];
         end
      end
   end

   // ------------------------------------------------------------
   // Lock bit and unlock sequence
   // ------------------------------------------------------------
   logic osc_wr;

   // Only a write to the low byte of the control word counts
   assign osc_wr = wr_fire && osc_hit && i_pstrb[0];

   // any write in between other than a repeated first key aborts the sequence
   always_comb begin
      unl_d = unl_q;
      if (wr_fire) begin
         unique case (unl_q)
            pin_select_pkg::UNL_IDLE: begin
               unl_d = (osc_wr && osc_byte == pin_select_pkg::UNLOCK_KEY1) ?
                       pin_select_pkg::UNL_SAW_KEY1 : pin_select_pkg::UNL_IDLE;
            end
            pin_select_pkg::UNL_SAW_KEY1: begin
               if (osc_wr && osc_byte == pin_select_pkg::UNLOCK_KEY2) begin
                  unl_d = pin_select_pkg::UNL_OPEN;
               end else if (osc_wr &&
                            osc_byte == pin_select_pkg::UNLOCK_KEY1) begin
                  unl_d = pin_select_pkg::UNL_SAW_KEY1;
               end else begin
                  unl_d = pin_select_pkg::UNL_IDLE;
               end
            end
            pin_select_pkg::UNL_OPEN: begin
               unl_d = pin_select_pkg::UNL_IDLE;
            end
            default: begin
               unl_d = pin_select_pkg::UNL_IDLE;
            end
         endcase
      end
   end

   // lock comes out of reset cleared
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         unl_q <= pin_select_pkg::UNL_IDLE;
         lock_q <= 1'h0;
      end else begin
         unl_q <= unl_d;
         // single write after both keys moves the lock
         if (osc_wr && unl_q == pin_select_pkg::UNL_OPEN) begin
            lock_q <= osc_byte[pin_select_pkg::LOCK_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // ------------------------------------------------------------
   logic [31:0] rd_in;
   logic [31:0] rd_data;

   // unimplemented bits stay zero in every read word
   always_comb begin
      rd_in = 32'h0000_0000;
      for (int f = 0; f < NF; f++) begin
         if (reg_idx == pin_select_pkg::FIELD_REG[f]) begin
            if (pin_select_pkg::FIELD_HI[f]) begin
               rd_in[pin_select_pkg::HI_LSB +: SW] = field_q[f];
            end else begin
               rd_in[pin_select_pkg::LO_LSB +: SW] = field_q[f];
            end
         end
      end
   end

   // Read source selection by decoded region
   assign rd_data = in_hit ? rd_in :
                    out_hit ? {18'h0, out_fn_q[1], 2'h0, out_fn_q[0]} :
                    osc_hit ? {25'h0, lock_q, 6'h00} : 32'h0000_0000;

   // Ready rises one cycle into the access phase, drops after
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pready_q <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && !mapped;
         if (access && !pready_q && !i_pwrite) begin
            prdata_q <= rd_data;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin synchroniser and peripheral mux register
   // ------------------------------------------------------------
   // Pins are asynchronous; second stage alone feeds the muxes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         periph_q <= '0;
      end else begin
         pin_s1_q <= i_pin_in;
         pin_s2_q <= pin_s1_q;
         periph_q <= pin_select_pkg::periph_in_s'(pick[NF-1:0]);
      end
   end

   // ------------------------------------------------------------
   // Pin output drive
   // ------------------------------------------------------------
   logic [1:0] drv_out;
   logic [1:0] drv_en;

   // decode function codes for the two mapped pins
   for (genvar k = 0; k < 2; k++) begin : g_outfn
      assign drv_en[k] = (out_fn_q[k] == pin_select_pkg::FN_SER1_TX) ||
                         (out_fn_q[k] == pin_select_pkg::FN_SER1_RTS);
      assign drv_out[k] = (out_fn_q[k] == pin_select_pkg::FN_SER1_TX) ?
                          i_ser1_tx :
                          (out_fn_q[k] == pin_select_pkg::FN_SER1_RTS) ?
                          i_ser1_rts : 1'h0;
   end

   // Unmapped pins stay released so pin logic elsewhere keeps them
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_out_q <= '0;
         pin_oe_n_q <= '1;
      end else begin
         pin_out_q <= '0;
         pin_oe_n_q <= '1;
         pin_out_q[pin_select_pkg::OUT_PIN_A] <= drv_out[0];
         pin_out_q[pin_select_pkg::OUT_PIN_B] <= drv_out[1];
         pin_oe_n_q[pin_select_pkg::OUT_PIN_A] <= !drv_en[0];
         pin_oe_n_q[pin_select_pkg::OUT_PIN_B] <= !drv_en[1];
      end
   end

   // Outputs come straight from flops
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_prdata = prdata_q;
   assign o_periph = periph_q;
   assign o_pin_out = pin_out_q;
   assign o_pin_oe_n = pin_oe_n_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   locked_write_a: assert property (
      (wr_fire && lock_q) |=> ($stable(field_q) && $stable(out_fn_q)))
      else $error("mapping changed while locked");

   read_zero_bits_a: assert property (
      (o_pready && in_hit && !i_pwrite) |->
      ((o_prdata & pin_select_pkg::UNUSED_MASK) == 32'h0))
      else $error("unimplemented bits read nonzero");

   reset_values_a: assert property (
      disable iff (1'b0) !i_rst_n |=>
      (field_q == {NF{pin_select_pkg::IN_SEL_RESET}} && !lock_q &&
       out_fn_q == '0 && o_pin_oe_n == '1))
      else $error("wrong values after reset");

   irq1_field_a: assert property (
      (map_wr_ok && in_hit && reg_idx == 4'h0 && i_pstrb[1]) |=>
      field_q[0] == $past(i_pwdata[13:8]))
      else $error("irq1 selector not loaded from bits 13-8");

   irq4_field_a: assert property (
      (map_wr_ok && in_hit && reg_idx == 4'h2 && i_pstrb[0]) |=>
      (field_q[3] == $past(i_pwdata[5:0])) ##1 $stable(field_q[2]))
      else $error("irq4 selector not loaded from bits 5-0");

   invalid_sel_a: assert property (
      ({1'b0, field_q[8]} >= PIN_LIMIT) |=> !o_periph.capture[0])
      else $error("invalid selector passed a pin");

   mux_path_a: assert property (
      ($stable(field_q[0]) && {1'b0, field_q[0]} < PIN_LIMIT) |=>
      o_periph.ext_irq[0] == $past(pin_ext[field_q[0]]))
      else $error("irq1 input not following its pin");

   ser_tx_a: assert property (
      (out_fn_q[0] == pin_select_pkg::FN_SER1_TX) |=>
      (!o_pin_oe_n[2] && o_pin_out[2] == $past(i_ser1_tx)))
      else $error("pin 2 not driven by serial transmit");

   ser_rts_a: assert property (
      (out_fn_q[1] == pin_select_pkg::FN_SER1_RTS) |=>
      (!o_pin_oe_n[3] && o_pin_out[3] == $past(i_ser1_rts)))
      else $error("pin 3 not driven by request-to-send");

   lock_key_a: assert property (
      $changed(lock_q) |-> $past(unl_q) == pin_select_pkg::UNL_OPEN)
      else $error("lock moved without unlock keys");

   unmapped_err_a: assert property (
      o_pready |-> (o_pslverr == !mapped))
      else $error("error flag disagrees with address map");

   unlock_seen_c: cover property (unl_q == pin_select_pkg::UNL_OPEN);
   lock_set_c: cover property ($rose(lock_q));
   locked_try_c: cover property (wr_fire && lock_q && in_hit);
   remap_c: cover property (fld_we[8] ##2 o_periph.capture[0]);

endmodule

`default_nettype wire

// ### pin_select_pkg.sv
// Constants, field table and carrier types of the remappable input select
package pin_select_pkg;

   // ------------------------------------------------------------
   // Bus geometry and register offsets
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int SEL_W = 6;
   localparam int IDX_SPAN = 64;
   localparam logic [ADDR_W-1:0] OUT_SEL_OFFSET = 12'h040;
   localparam logic [ADDR_W-1:0] OSC_CTRL_OFFSET = 12'h080;
   // One bit per input selector index that is implemented (0-4, 7-9)
   localparam logic [15:0] IN_REG_MAP = 16'h039F;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;
   localparam int STRB_LO = 0;
   localparam int STRB_HI = 1;
   localparam logic [DATA_W-1:0] UNUSED_MASK = 32'hFFFF_C0C0;
   localparam int LOCK_BIT = 6;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
   localparam logic [7:0] UNLOCK_KEY2 = 8'h57;

   // Fields: ext irq 1-4, timer clock 2-5, capture 1-6
   localparam int NUM_FIELDS = 14;
   localparam logic [3:0] FIELD_REG [NUM_FIELDS] = '{
      4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h4,
      4'h4, 4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9};
   localparam logic FIELD_HI [NUM_FIELDS] = '{
      1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0,
      1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

   // ------------------------------------------------------------
   // Reset values and output function codes
   // ------------------------------------------------------------
   localparam logic [SEL_W-1:0] IN_SEL_RESET = 6'h3F;
   localparam logic [SEL_W-1:0] OUT_FN_RESET = 6'h00;
   localparam logic [SEL_W-1:0] FN_SER1_TX = 6'h03;
   localparam logic [SEL_W-1:0] FN_SER1_RTS = 6'h04;
   localparam int OUT_PIN_A = 2;
   localparam int OUT_PIN_B = 3;

   // Unlock sequence states
   typedef enum logic [1:0] {
      UNL_IDLE,
      UNL_SAW_KEY1,
      UNL_OPEN
   } unlock_e;

   // Peripheral inputs, packed so bit f is field f
   typedef struct packed {
      logic [5:0] capture;
      logic [3:0] tmr_clk;
      logic [3:0] ext_irq;
   } periph_in_s;

endpackage

// ### pin_side_model.sv
// Far-side model: pad levels and serial port 1 outputs
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Pads and serial port seen by the pin select
// ------------------------------------------------------------
module pin_side_model #(
   parameter int NUM_PINS = 46
) (
   input wire logic [NUM_PINS-1:0] i_level, // Requested pad levels
   input wire logic i_tx, // Requested transmit level
   input wire logic i_rts, // Requested handshake level
   output logic [NUM_PINS-1:0] o_pin, // Pad levels into the block
   output logic o_ser1_tx, // Serial port 1 transmit
   output logic o_ser1_rts // Serial port 1 request-to-send
);
   // Pads pass levels straight on; the block owns the synchronising
   assign o_pin = i_level;
   assign o_ser1_tx = i_tx;
   assign o_ser1_rts = i_rts;
endmodule

`default_nettype wire

// ### remappable_input_pin_select_tb.sv
// Self-checking bench for the remappable input pin select
`timescale 1ns/1ps
`default_nettype none

module remappable_input_pin_select_tb;
   localparam int NP = 46;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic [NP-1:0] lvl = '0;
   logic tx = 1'b0;
   logic rts = 1'b0;
   logic pready, pslverr, ser_tx, ser_rts;
   logic [31:0] prdata;
   logic [NP-1:0] pins, pout, poe_n;
   pin_select_pkg::periph_in_s periph;
   logic [13:0] pv;
   logic [31:0] rd;
   logic [63:0] r64;
   logic [5:0] p;
   logic err;
   integer seed = 36;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int idx [8] = '{0, 1, 2, 3, 4, 7, 8, 9};

   assign pv = periph;

   remappable_input_pin_select #(.NUM_PINS(NP)) i_remappable_input_pin_select (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .i_pin_in(pins), .i_ser1_tx(ser_tx), .i_ser1_rts(ser_rts),
      .o_pin_out(pout), .o_pin_oe_n(poe_n), .o_periph(periph));

   pin_side_model #(.NUM_PINS(NP)) i_pin_side_model (
      .i_level(lvl), .i_tx(tx), .i_rts(rts), .o_pin(pins),
      .o_ser1_tx(ser_tx), .o_ser1_rts(ser_rts));

   // ------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial begin
      forever #20 i_clk = ~i_clk;
   end

   // A hung handshake would otherwise run forever
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One transfer; holds the request until ready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      // One wait state: ready is seen at the second access edge
      chk(n, 32'h2);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic set_lock(input logic v);
      apb(1'b1, 12'h080, 32'h46);
      apb(1'b1, 12'h080, 32'h57);
      apb(1'b1, 12'h080, {25'h0, v, 6'h0});
   endtask

   // Implemented bits of each input selector word
   function automatic logic [31:0] msk(input int n);
      return (n == 0) ? 32'h3F00 : (n == 2) ? 32'h003F : 32'h3F3F;
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      chk({18'h0, pv}, 32'h0);
      chk({31'h0, &poe_n}, 32'h1);
      chk({31'h0, |pout}, 32'h0);
      foreach (idx[i]) begin
         apb(1'b0, 12'(idx[i] * 4), 32'h0);
         chk(rd, msk(idx[i]));
      end
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      $display("test reset values done");
      // All ones, then random words: only field bits may stick
      for (int k = 0; k < 2; k++) begin
         foreach (idx[i]) begin
            r64[31:0] = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
            apb(1'b1, 12'(idx[i] * 4), r64[31:0]);
            apb(1'b0, 12'(idx[i] * 4), 32'h0);
            chk(rd, r64[31:0] & msk(idx[i]));
         end
      end
      $display("test readback masking done");
      // Each field picks a pin; flip pads to rule out a lucky match
      for (int f = 0; f < 14; f++) begin
         p = (f == 0) ? 6'h00 : (f == 13) ? 6'(NP - 1) :
             6'({$random(seed)} % NP);
         apb(1'b1, {6'h0, pin_select_pkg::FIELD_REG[f], 2'b00},
             {18'h0, p, 2'b00, p});
         r64 = {$random(seed), $random(seed)};
         lvl <= r64[NP-1:0];
         repeat (4) @(posedge i_clk);
         chk({31'h0, pv[f]}, {31'h0, lvl[p]});
         lvl <= ~lvl;
         repeat (4) @(posedge i_clk);
         chk({31'h0, pv[f]}, {31'h0, lvl[p]});
      end
      lvl <= '1;
      apb(1'b1, 12'h000, 32'h2E00);
      repeat (4) @(posedge i_clk);
      chk({31'h0, pv[0]}, 32'h0);
      // Strobe low on the low lane must keep that field
      apb(1'b1, 12'h01C, 32'h1516);
      pstrb <= 4'h2;
      apb(1'b1, 12'h01C, 32'h2A2B);
      pstrb <= 4'hF;
      apb(1'b0, 12'h01C, 32'h0);
      chk(rd, 32'h2A16);
      $display("test input mapping done");
      apb(1'b1, 12'h00C, 32'h1234);
      // A lock write without the keys must not move the bit
      apb(1'b1, 12'h080, 32'h40);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      set_lock(1'b1);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h40);
      apb(1'b1, 12'h00C, 32'h2A15);
      apb(1'b1, 12'h040, 32'h0403);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h1234);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      set_lock(1'b0);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      $display("test lock done");
      apb(1'b1, 12'h040, 32'h0403);
      tx <= 1'b1;
      rts <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk({28'h0, pout[3:2], poe_n[3:2]}, 32'h4);
      tx <= 1'b0;
      rts <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk({28'h0, pout[3:2], poe_n[3:2]}, 32'h8);
      apb(1'b1, 12'h040, 32'h0505);
      repeat (3) @(posedge i_clk);
      chk({30'h0, poe_n[3:2]}, 32'h3);
      $display("test output functions done");
      apb(1'b0, 12'h014, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h018, 32'h3F3F);
      chk({31'h0, err}, 32'h1);
      $display("test unmapped access done");
      // Reset in mid-run from a locked, written state
      set_lock(1'b1);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      apb(1'b0, 12'h080, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h3F3F);
      $display("test mid-run reset done");
      tally_and_finish();
   end
endmodule

`default_nettype wire
